// ===== hw/slpp_pkg.sv
/*
 * Constants for the serial latch program port: word layout, latch
 * select codes, observe mux codes and reset values.
 * Assumes a single system clock domain plus the serial link clock.
 */
package slpp_pkg;
    localparam int          WORD_W       = 24;
    localparam logic [1:0]  SEL_CONTROL  = 2'h0;
    localparam logic [1:0]  SEL_REF_DIV  = 2'h1;
    localparam logic [1:0]  SEL_FB_DIV   = 2'h2;
    localparam logic [1:0]  SEL_TEST     = 2'h3;
    // Observe select field position in control latch
    localparam int          OBS_LSB      = 2;
    // Software power-down bits in control latch; slpp_port decodes PD1_BIT only, PD2_BIT has no effect
    localparam int          PD1_BIT      = 20;
    localparam int          PD2_BIT      = 21;
    localparam logic [23:0] LATCH_RST    = 24'h000000;
    // Observe mux codes
    localparam logic [2:0]  OBS_LOW      = 3'h0;
    localparam logic [2:0]  OBS_DLOCK    = 3'h1;
    localparam logic [2:0]  OBS_NDIV     = 3'h2;
    localparam logic [2:0]  OBS_HIGH     = 3'h3;
    localparam logic [2:0]  OBS_RDIV     = 3'h4;
    localparam logic [2:0]  OBS_ALOCK    = 3'h5;
    localparam logic [2:0]  OBS_REF      = 3'h6;
endpackage

// ===== hw/slpp_port.sv
/*
 * Serial latch program port: shift register on the serial clock,
 * latches and power/observe control on the system clock.
 * Assumes load strobe pulses last several system clocks.
 */
`timescale 1ns/100ps
module slpp_port (
    // System
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        clk_en,
    // Serial link
    input  wire logic        ser_clock,
    input  wire logic        ser_data,
    input  wire logic        load_strobe,
    // Chip enable pin
    input  wire logic        chip_enable,
    // Observe sources
    input  wire logic        lock_digital,
    input  wire logic        lock_analog,
    input  wire logic        rf_scaled,
    input  wire logic        ref_scaled,
    // Outputs
    output logic             observe_output,
    output logic             pump_output_en,
    output logic             powered_up,
    output logic             ref_path_switch_a,
    output logic             ref_path_switch_b,
    output logic             ref_bypass_switch,
    output logic [23:0]      control_latch,
    output logic [23:0]      ref_div_latch,
    output logic [23:0]      fb_div_latch,
    output logic [23:0]      test_latch
);

    ////////////////////////////////////////////////////////////////////////
    // Link domain shift register
    logic [23:0] shift_reg;
    logic [23:0] shift_next;

    // Next shift value, MSB first
    always_comb begin
        shift_next = {shift_reg[22:0], ser_data};
    end

    // Shift on serial clock rising edge
    always_ff @(posedge ser_clock or negedge nrst) begin
        if (!nrst) begin
            shift_reg <= slpp_pkg::LATCH_RST;
        end else begin
            shift_reg <= shift_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers for pins
    logic [1:0] sync1_reg;
    logic [1:0] sync2_reg;
    logic       le_prev_reg;
    logic [1:0] sync1_next;
    logic [1:0] sync2_next;
    logic       le_prev_next;

    // Two-stage capture of strobe, chip enable
    always_comb begin
        sync1_next   = {chip_enable, load_strobe};
        sync2_next   = sync1_reg;
        le_prev_next = sync2_reg[0];
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sync1_reg   <= 2'h0;
            sync2_reg   <= 2'h0;
            le_prev_reg <= 1'b0;
        end else if (clk_en) begin
            sync1_reg   <= sync1_next;
            sync2_reg   <= sync2_next;
            le_prev_reg <= le_prev_next;
        end
    end

    logic le_rise;
    logic ce_sync;
    assign le_rise = sync2_reg[0] & ~le_prev_reg;
    assign ce_sync = sync2_reg[1];

    ////////////////////////////////////////////////////////////////////////
    // Latches; shift word is static while strobe is high
    logic [23:0] ctl_reg;
    logic [23:0] ref_reg;
    logic [23:0] fb_reg;
    logic [23:0] tst_reg;
    logic [23:0] ctl_next;
    logic [23:0] ref_next;
    logic [23:0] fb_next;
    logic [23:0] tst_next;

    // Route word to latch chosen by low two bits
    always_comb begin
        ctl_next = ctl_reg;
        ref_next = ref_reg;
        fb_next  = fb_reg;
        tst_next = tst_reg;
        if (le_rise) begin
            case (shift_reg[1:0])
                slpp_pkg::SEL_CONTROL: ctl_next = shift_reg;
                slpp_pkg::SEL_REF_DIV: ref_next = shift_reg;
                slpp_pkg::SEL_FB_DIV:  fb_next  = shift_reg;
                default:               tst_next = shift_reg;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctl_reg <= slpp_pkg::LATCH_RST;
            ref_reg <= slpp_pkg::LATCH_RST;
            fb_reg  <= slpp_pkg::LATCH_RST;
            tst_reg <= slpp_pkg::LATCH_RST;
        end else if (clk_en) begin
            ctl_reg <= ctl_next;
            ref_reg <= ref_next;
            fb_reg  <= fb_next;
            tst_reg <= tst_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power and observe outputs
    logic       pwr_reg;
    logic       obs_reg;
    logic       pwr_next;
    logic       obs_next;
    logic [2:0] obs_sel;

    assign obs_sel = ctl_reg[slpp_pkg::OBS_LSB +: 3];

    // Power state and observe mux
    always_comb begin
        pwr_next = ce_sync & ~ctl_reg[slpp_pkg::PD1_BIT];
        case (obs_sel)
            slpp_pkg::OBS_LOW:   obs_next = 1'b0;
            slpp_pkg::OBS_DLOCK: obs_next = lock_digital;
            slpp_pkg::OBS_NDIV:  obs_next = rf_scaled;
            slpp_pkg::OBS_HIGH:  obs_next = 1'b1;
            slpp_pkg::OBS_RDIV:  obs_next = ref_scaled;
            slpp_pkg::OBS_ALOCK: obs_next = lock_analog;
            slpp_pkg::OBS_REF:   obs_next = ref_scaled;
            default:             obs_next = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pwr_reg <= 1'b0;
            obs_reg <= 1'b0;
        end else if (clk_en) begin
            pwr_reg <= pwr_next;
            obs_reg <= obs_next;
        end
    end

    assign powered_up        = pwr_reg;
    assign pump_output_en    = pwr_reg;
    assign ref_path_switch_a = pwr_reg;
    assign ref_path_switch_b = pwr_reg;
    assign ref_bypass_switch = ~pwr_reg;
    assign observe_output    = obs_reg;
    assign control_latch     = ctl_reg;
    assign ref_div_latch     = ref_reg;
    assign fb_div_latch      = fb_reg;
    assign test_latch        = tst_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence strobe_rise_s;
        le_rise && clk_en;
    endsequence

    // Chip enable seen low through the synchronised path
    sequence power_down_s;
        clk_en && !ce_sync;
    endsequence

    // Latch loading and holding
    latch_load_ctl_a: assert property (@(posedge clock) disable iff (!nrst)
        strobe_rise_s and shift_reg[1:0] == 2'h0 |=> ctl_reg == $past(shift_reg))
        else $error("control latch not loaded");
    latch_load_ref_a: assert property (@(posedge clock) disable iff (!nrst)
        strobe_rise_s and shift_reg[1:0] == 2'h1 |=> ref_reg == $past(shift_reg))
        else $error("reference latch not loaded");
    latch_load_fb_a: assert property (@(posedge clock) disable iff (!nrst)
        strobe_rise_s and shift_reg[1:0] == 2'h2 |=> fb_reg == $past(shift_reg))
        else $error("feedback latch not loaded");
    test_latch_hold_a: assert property (@(posedge clock) disable iff (!nrst)
        strobe_rise_s and shift_reg[1:0] != 2'h3 |=> $stable(tst_reg))
        else $error("test latch written by other select");
    latch_hold_a: assert property (@(posedge clock) disable iff (!nrst)
        !le_rise |=> $stable(ref_reg) && $stable(ctl_reg) && $stable(fb_reg) && $stable(tst_reg))
        else $error("latch changed without strobe");

    // Shift path, power and observe
    shift_msb_a: assert property (@(posedge ser_clock) disable iff (!nrst)
        1'b1 |=> shift_reg[0] == $past(ser_data))
        else $error("serial bit not shifted");
    pump_off_a: assert property (@(posedge clock) disable iff (!nrst)
        power_down_s |=> !pump_output_en)
        else $error("pump driven while disabled");
    power_bits_a: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && ctl_reg[slpp_pkg::PD1_BIT] |=> !powered_up)
        else $error("power-down bit ignored");
    power_up_a: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && ce_sync && !ctl_reg[slpp_pkg::PD1_BIT] |=> powered_up)
        else $error("device stayed down while enabled");
    ref_switch_a: assert property (@(posedge clock) disable iff (!nrst)
        power_down_s |=> ref_bypass_switch && !ref_path_switch_a && !ref_path_switch_b)
        else $error("reference switches wrong in power-down");
    observe_lock_a: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && obs_sel == 3'h1 |=> observe_output == $past(lock_digital))
        else $error("observe output wrong");
    observe_high_a: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && obs_sel == slpp_pkg::OBS_HIGH |=> observe_output)
        else $error("observe output not forced high");
endmodule

// ===== sim/slpp_host_model.sv
/* Serial controller model: shifts 24-bit words on its own link clock
   and pulses the load strobe. Assumes the bench calls its tasks. */
`timescale 1ns/100ps
module slpp_host_model (
    // Serial link
    output logic ser_clock,
    output logic ser_data,
    output logic load_strobe
);
    // Idle link: clock still, strobe low
    initial begin
        ser_clock   = 1'b0;
        ser_data    = 1'b1;
        load_strobe = 1'b0;
    end
    // Word goes out MSB first, clock runs only in the frame
    task automatic shift_word(input logic [23:0] w);
        #5.3;
        for (int i = 23; i >= 0; i--) begin
            ser_data = w[i];
            #16 ser_clock = 1'b1;
            #16 ser_clock = 1'b0;
        end
        ser_data = ~w[0]; // Released line shows the inverse
    endtask
    // Strobe held long past the sync delay
    task automatic pulse_strobe();
        #20 load_strobe = 1'b1;
        #64 load_strobe = 1'b0;
        #20;
    endtask
endmodule

// ===== sim/slpp_port_tb_top.sv
/* Bench for the serial latch program port.
   Assumes slpp_host_model drives the serial link. */
`timescale 1ns/100ps
module slpp_port_tb_top;
    logic        clock, nrst, chip_enable, ser_clock, ser_data, load_strobe;
    logic        lock_digital, lock_analog, rf_scaled, ref_scaled;
    logic        observe_output, pump_output_en, powered_up, sw_a, sw_b, sw_byp;
    logic [23:0] lat [4];
    int          err_count, checked;

    slpp_port i_slpp_port (.clock(clock), .nrst(nrst), .clk_en(1'b1), .ser_clock(ser_clock),
        .ser_data(ser_data), .load_strobe(load_strobe), .chip_enable(chip_enable),
        .lock_digital(lock_digital), .lock_analog(lock_analog), .rf_scaled(rf_scaled),
        .ref_scaled(ref_scaled), .observe_output(observe_output), .pump_output_en(pump_output_en),
        .powered_up(powered_up), .ref_path_switch_a(sw_a), .ref_path_switch_b(sw_b),
        .ref_bypass_switch(sw_byp), .control_latch(lat[0]), .ref_div_latch(lat[1]),
        .fb_div_latch(lat[2]), .test_latch(lat[3]));
    slpp_host_model i_slpp_host_model (.ser_clock(ser_clock), .ser_data(ser_data), .load_strobe(load_strobe));

    // System clock
    initial clock = 1'b0;
    always #4 clock = ~clock;

    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic load(input logic [23:0] w);
        i_slpp_host_model.shift_word(w);
        i_slpp_host_model.pulse_strobe();
        wait_clk(3);
    endtask
    function automatic logic [23:0] ctl(input logic pd, input logic [2:0] obs);
        return (24'(pd) << slpp_pkg::PD1_BIT) | (24'(obs) << slpp_pkg::OBS_LSB);
    endfunction
    function automatic logic [23:0] pwr();
        return 24'({powered_up, pump_output_en, sw_a, sw_b, sw_byp});
    endfunction

    ////////////////////////////////////////////////////////////////
    // Power-up order, each latch lands alone; test latch left alone
    task automatic select_codes();
        logic [23:0] w [3];
        logic [23:0] e [4];
        int          ord [3] = '{1, 0, 2};
        w[0] = ctl(1'b0, slpp_pkg::OBS_ALOCK) | 24'(slpp_pkg::SEL_CONTROL);
        w[1] = {22'h2C3A5F, slpp_pkg::SEL_REF_DIV};
        w[2] = {22'h135AC0, slpp_pkg::SEL_FB_DIV};
        e = '{default: slpp_pkg::LATCH_RST};
        for (int k = 0; k < 3; k++) begin
            load(w[ord[k]]);
            e[ord[k]] = w[ord[k]];
            for (int i = 0; i < 4; i++) check(lat[i], e[i]);
        end
    endtask
    // Only the last 24 bits count, latches hold between strobes
    task automatic latest_bits();
        i_slpp_host_model.shift_word({22'h3FFFFF, slpp_pkg::SEL_FB_DIV});
        wait_clk(20);
        check(lat[2], 24'h4D6B02);
        i_slpp_host_model.shift_word({22'h0A0A0A, slpp_pkg::SEL_REF_DIV});
        i_slpp_host_model.pulse_strobe();
        wait_clk(3);
        check(lat[1], {22'h0A0A0A, slpp_pkg::SEL_REF_DIV});
        check(lat[2], 24'h4D6B02);
        check(lat[0], ctl(1'b0, slpp_pkg::OBS_ALOCK));
    endtask
    // Chip enable and software power-down
    task automatic power_control();
        chip_enable <= 1'b1;
        wait_clk(5);
        check(pwr(), 24'h00001E);
        chip_enable <= 1'b0;
        wait_clk(5);
        check(pwr(), 24'h000001);
        chip_enable <= 1'b1;
        load(ctl(1'b1, 3'h0));
        wait_clk(4);
        check(24'(powered_up), 24'h000000);
    endtask
    // Every observe code against three source patterns
    task automatic observe_mux();
        logic [3:0] pat [3] = '{4'h9, 4'h5, 4'h2};
        logic       e;
        for (int c = 0; c < 8; c++) begin
            load(ctl(1'b0, 3'(c)));
            for (int p = 0; p < 3; p++) begin
                {lock_digital, lock_analog, rf_scaled, ref_scaled} <= pat[p];
                wait_clk(3);
                case (3'(c))
                    slpp_pkg::OBS_DLOCK: e = pat[p][3];
                    slpp_pkg::OBS_ALOCK: e = pat[p][2];
                    slpp_pkg::OBS_NDIV: e = pat[p][1];
                    slpp_pkg::OBS_RDIV, slpp_pkg::OBS_REF: e = pat[p][0];
                    slpp_pkg::OBS_HIGH: e = 1'b1;
                    default: e = 1'b0;
                endcase
                check(24'(observe_output), 24'(e));
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        nrst = 1'b0;
        chip_enable = 1'b0;
        {lock_digital, lock_analog, rf_scaled, ref_scaled} = 4'h0;
        err_count = 0;
        checked = 0;
        wait_clk(12);
        for (int i = 0; i < 4; i++) check(lat[i], slpp_pkg::LATCH_RST);
        check(pwr(), 24'h000001);
        nrst <= 1'b1;
        wait_clk(2);
        select_codes();
        latest_bits();
        power_control();
        observe_mux();
        close_out();
    end
endmodule
